// >>> include/setup_menu_pkg.sv
package setup_menu_pkg;
   // clock and time base
   localparam int CLK_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS_DFLT = MS_NS / CLK_NS;
   // display and key timing, in milliseconds
   localparam logic [11:0] ELAPSED_MS = 12'hbb8;
   localparam logic [11:0] PROMPT_MS = 12'h320;
   localparam logic [11:0] ERR_MS = 12'h5dc;
   localparam logic [11:0] REPEAT_MS = 12'h12c;
   localparam logic [11:0] RESET_HOLD_MS = 12'h7d0;
   localparam logic [11:0] BLINK_MS = 12'h0fa;
   localparam logic [11:0] SAVE_MS = 12'h3e8;
   // key positions in the key vector
   localparam int KEY_SETUP = 0;
   localparam int KEY_RESET = 1;
   localparam int KEY_DSEL = 2;
   localparam int KEY_VADJ = 3;
   localparam int KEY_TIME = 4;
   // digit printed on each key, key i at bits [4i+3:4i]
   localparam logic [19:0] KEY_DIGITS = 20'h54321;
   localparam logic [15:0] PASSCODE = 16'h3254;
   localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
   localparam logic [2:0] LAST_CH = 3'h7;
   localparam logic [2:0] LAST_DISP_OPT = 3'h5;
   localparam logic [2:0] SYS_NV_ADDR = 3'h7;
   // register offsets and control fields
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_READING = 8'h08;
   localparam int CTRL_NOBLE_BIT = 0;
   localparam int CTRL_MV_BIT = 1;
   localparam int RAW_SHIFT = 12;
   localparam logic [11:0] RAW_OVER = 12'hfff;

   typedef enum logic [2:0] {
      IN_J = 3'h0, IN_K = 3'h1, IN_T = 3'h2, IN_E = 3'h3,
      IN_CURRENT = 3'h4, IN_VOLT = 3'h5, IN_NOBLE = 3'h6, IN_MILLIVOLT = 3'h7
   } in_type_t;

   typedef enum logic [4:0] {
      ST_NORMAL = 5'h00, ST_ELAPSED = 5'h01, ST_BANNER = 5'h02, ST_CODE = 5'h03,
      ST_CODE_ERR = 5'h04, ST_MENU = 5'h05, ST_CH_SEL = 5'h06, ST_CH_TYPE = 5'h07,
      ST_CH_ONOFF = 5'h08, ST_CH_TUNITS = 5'h09, ST_CH_DP = 5'h0a, ST_CH_HI = 5'h0b,
      ST_CH_LO = 5'h0c, ST_CH_OFS = 5'h0d, ST_CH_TARE = 5'h0e, ST_CH_SP = 5'h0f,
      ST_CH_LIM = 5'h10, ST_CH_DB = 5'h11, ST_CH_RLY = 5'h12, ST_CH_UNITS = 5'h13,
      ST_SYS_DISP = 5'h14, ST_SYS_ELT = 5'h15, ST_SYS_LATCH = 5'h16,
      ST_SYS_RANGE = 5'h17, ST_SAVE = 5'h18
   } state_t;

   typedef struct packed {
      in_type_t in_type;
      logic on;
      logic temp_f;
      logic [1:0] dp;
      logic [15:0] hi;
      logic [15:0] lo;
   } chan_cfg_t;

   typedef struct packed {
      logic [2:0] disp_opt;
      logic show_elapsed;
      logic latch;
      logic [1:0] range;
   } sys_cfg_t;

   typedef struct packed {
      state_t state;
      logic prompt;
      logic [15:0] value;
      logic [1:0] dp;
      logic [1:0] cursor;
      logic blink;
   } disp_t;

   typedef struct packed {
      logic valid;
      logic [2:0] ch;
      logic signed [17:0] value;
      logic err;
   } reading_t;

   localparam chan_cfg_t CHAN_RESET = '{IN_J, 1'b1, 1'b0, 2'h0, 16'h1000, 16'h0000};
   localparam chan_cfg_t CHAN_OFF = '{IN_J, 1'b0, 1'b0, 2'h0, 16'h0000, 16'h0000};
   localparam sys_cfg_t SYS_RESET = '{3'h1, 1'b0, 1'b0, 2'h0};

   // four BCD digits to binary
   function automatic logic signed [17:0] bcd2bin(input logic [15:0] v);
      return 18'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
   endfunction
endpackage

// >>> hw/scale_map.sv
// maps a raw sample linearly between low scale and high scale
module scale_map (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire logic [2:0] sample_ch,
   input wire logic [11:0] sample_raw,
   input wire setup_menu_pkg::chan_cfg_t cfg,
   output setup_menu_pkg::reading_t rd
);
   import setup_menu_pkg::*;

   logic signed [17:0] lo_bin;
   logic signed [17:0] span;
   logic signed [31:0] prod;

   // full scale is taken as 2^12 so the divide is a shift, at a cost of one lsb at the top
   assign lo_bin = bcd2bin(cfg.lo);
   assign span = bcd2bin(cfg.hi) - lo_bin;
   assign prod = span * $signed({1'b0, sample_raw});

   // channels set off are skipped entirely: no result and no error
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd <= '0;
      end else begin
         rd.valid <= sample_valid && cfg.on;
         if (sample_valid && cfg.on) begin
            rd.ch <= sample_ch;
            rd.value <= lo_bin + 18'(prod >>> RAW_SHIFT);
            rd.err <= (sample_raw == RAW_OVER);
         end
      end
   end
endmodule

// >>> hw/setup_menu_ctrl.sv
// The register offsets and the address-and-strobe port were decided locally.
module setup_menu_ctrl #(
   parameter int CYC_PER_MS = setup_menu_pkg::CYC_PER_MS_DFLT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [4:0] keys,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [2:0] sample_ch,
   input wire logic [11:0] sample_raw,
   output setup_menu_pkg::disp_t disp,
   output logic setup_lamp,
   output logic nv_wr,
   output logic [2:0] nv_addr,
   output setup_menu_pkg::chan_cfg_t nv_data,
   output setup_menu_pkg::reading_t reading
);
   import setup_menu_pkg::*;

   state_t state_q, state_d;
   logic [4:0] keys_q;
   logic [4:0] press;
   logic ps, pva, pdsel, rva, any_press;
   logic [14:0] div_q;
   logic ms_tick_q;
   logic [11:0] tmr_q, rhold_q, rep_q, blink_cnt_q;
   logic st_chg, in_setup, rhold_done, va_step, blink_q;
   logic [11:0] code_q;
   logic [1:0] code_cnt_q, attempts_q;
   logic [3:0] digit;
   logic code_ok;
   logic [2:0] ch_q;
   logic sel_sys_q;
   logic [15:0] val_q;
   logic [1:0] cursor_q;
   logic dir_up_q;
   chan_cfg_t chan_edit_q [1:7];
   chan_cfg_t chan_store_q [1:7];
   sys_cfg_t sys_edit_q, sys_store_q;
   chan_cfg_t sel_cfg;
   logic [2:0] nv_idx_q;
   logic nv_run_q;
   logic [1:0] ctrl_q;
   logic signed [17:0] last_read_q;

   // next input type in the option's own cycle
   function automatic in_type_t next_type(input in_type_t t, input logic noble, input logic mv);
      in_type_t n;
      n = IN_CURRENT;
      if (mv) begin
         if (t == IN_CURRENT) n = IN_VOLT;
         else if (t == IN_VOLT) n = IN_MILLIVOLT;
      end else if (noble) begin
         if (t == IN_NOBLE) n = IN_CURRENT;
         else if (t == IN_CURRENT) n = IN_VOLT;
         else n = IN_NOBLE;
      end else begin
         unique case (t)
            IN_J: n = IN_K;
            IN_K: n = IN_T;
            IN_T: n = IN_E;
            IN_E: n = IN_CURRENT;
            IN_CURRENT: n = IN_VOLT;
            default: n = IN_J;
         endcase
      end
      return n;
   endfunction

   function automatic logic is_temp(input in_type_t t);
      return (t <= IN_E) || (t == IN_NOBLE);
   endfunction

   // step one BCD digit up or down with wrap
   function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] pos,
                                             input logic up);
      logic [3:0] d;
      logic [15:0] r;
      r = v;
      d = v[pos*4 +: 4];
      if (up) d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
      else d = (d == 4'h0) ? 4'h9 : d - 4'h1;
      r[pos*4 +: 4] = d;
      return r;
   endfunction

   // key edges; keys are levels already synchronous to mclk
   always_ff @(posedge mclk) begin
      if (!rst_n) keys_q <= 5'h00;
      else keys_q <= keys;
   end
   assign press = keys & ~keys_q;
   assign ps = press[KEY_SETUP];
   assign pva = press[KEY_VADJ];
   assign pdsel = press[KEY_DSEL];
   assign rva = keys_q[KEY_VADJ] & ~keys[KEY_VADJ];
   assign any_press = |press;

   // digit of the lowest pressed key
   always_comb begin
      digit = 4'h0;
      for (int i = 4; i >= 0; i--) begin
         if (press[i]) digit = KEY_DIGITS[i*4 +: 4];
      end
   end
   assign code_ok = ({code_q, digit} == PASSCODE);

   // millisecond tick divider
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_q <= 15'h0000;
         ms_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= (div_q == 15'(CYC_PER_MS - 1));
         div_q <= (div_q == 15'(CYC_PER_MS - 1)) ? 15'h0000 : div_q + 15'h0001;
      end
   end

   assign st_chg = (state_d != state_q);
   assign in_setup = !(state_q inside {ST_NORMAL, ST_ELAPSED, ST_SAVE});
   assign rhold_done = (rhold_q >= RESET_HOLD_MS);
   assign va_step = pva || (keys_q[KEY_VADJ] && ms_tick_q && rep_q >= REPEAT_MS);

   // time in state, reset hold and adjust repeat timers
   always_ff @(posedge mclk) begin
      if (!rst_n || st_chg) tmr_q <= 12'h000;
      else if (ms_tick_q && tmr_q != 12'hfff) tmr_q <= tmr_q + 12'h001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !keys_q[KEY_RESET] || !in_setup) rhold_q <= 12'h000;
      else if (ms_tick_q && !rhold_done) rhold_q <= rhold_q + 12'h001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !keys_q[KEY_VADJ] || va_step) rep_q <= 12'h000;
      else if (ms_tick_q) rep_q <= rep_q + 12'h001;
   end

   // menu sequencer; a full reset hold overrides every setup step
   always_comb begin
      state_d = state_q;
      if (in_setup && rhold_done) begin
         state_d = ST_SAVE;
      end else begin
         unique case (state_q)
            ST_NORMAL: if (ps) state_d = ST_ELAPSED;
            ST_ELAPSED: begin
               if (ps) state_d = ST_BANNER;
               else if (tmr_q >= ELAPSED_MS) state_d = ST_NORMAL;
            end
            ST_BANNER: if (tmr_q >= PROMPT_MS) state_d = ST_CODE;
            ST_CODE: begin
               if (any_press && code_cnt_q == 2'h3) state_d = code_ok ? ST_MENU : ST_CODE_ERR;
            end
            ST_CODE_ERR: begin
               if (tmr_q >= ERR_MS) state_d = (attempts_q == MAX_ATTEMPTS) ? ST_NORMAL : ST_CODE;
            end
            ST_MENU: if (ps) state_d = sel_sys_q ? ST_SYS_DISP : ST_CH_SEL;
            ST_CH_SEL: if (ps) state_d = ST_CH_TYPE;
            ST_CH_TYPE: if (ps) state_d = ST_CH_ONOFF;
            ST_CH_ONOFF: begin
               if (ps) state_d = is_temp(chan_edit_q[ch_q].in_type) ? ST_CH_TUNITS : ST_CH_DP;
            end
            ST_CH_TUNITS: if (ps) state_d = ST_CH_SP;
            ST_CH_DP: if (ps) state_d = ST_CH_HI;
            ST_CH_HI: if (ps) state_d = ST_CH_LO;
            ST_CH_LO: if (ps) state_d = ST_CH_OFS;
            ST_CH_OFS: if (ps) state_d = ST_CH_TARE;
            ST_CH_TARE: if (ps) state_d = ST_CH_SP;
            ST_CH_SP: if (ps) state_d = ST_CH_LIM;
            ST_CH_LIM: if (ps) state_d = ST_CH_DB;
            ST_CH_DB: if (ps) state_d = ST_CH_RLY;
            ST_CH_RLY: if (ps) state_d = ST_CH_UNITS;
            ST_CH_UNITS: if (ps) state_d = ST_MENU;
            ST_SYS_DISP: if (ps) state_d = ST_SYS_ELT;
            ST_SYS_ELT: if (ps) state_d = ST_SYS_LATCH;
            ST_SYS_LATCH: if (ps) state_d = ST_SYS_RANGE;
            ST_SYS_RANGE: if (ps) state_d = ST_MENU;
            ST_SAVE: if (tmr_q >= SAVE_MS && !nv_run_q) state_d = ST_NORMAL;
            default: state_d = ST_NORMAL;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) state_q <= ST_NORMAL;
      else state_q <= state_d;
   end

   // passcode digits and attempts; a fresh entry always grants three tries
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         code_q <= 12'h000;
         code_cnt_q <= 2'h0;
         attempts_q <= 2'h0;
      end else begin
         if (st_chg && state_d == ST_BANNER) attempts_q <= 2'h0;
         else if (st_chg && state_d == ST_CODE_ERR) attempts_q <= attempts_q + 2'h1;
         if (st_chg) begin
            code_q <= 12'h000;
            code_cnt_q <= 2'h0;
         end else if (state_q == ST_CODE && any_press) begin
            code_q <= {code_q[7:0], digit};
            code_cnt_q <= code_cnt_q + 2'h1;
         end
      end
   end

   // menu choice and channel pointer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_sys_q <= 1'b0;
         ch_q <= 3'h1;
      end else begin
         if (st_chg && state_q == ST_CODE) sel_sys_q <= 1'b0;
         else if (state_q == ST_MENU && pva) sel_sys_q <= !sel_sys_q;
         if (state_q == ST_CH_SEL && pva) ch_q <= (ch_q == LAST_CH) ? 3'h1 : ch_q + 3'h1;
      end
   end

   // digit editor for the scale values
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         val_q <= 16'h0000;
         cursor_q <= 2'h3;
         dir_up_q <= 1'b1;
      end else if (st_chg) begin
         val_q <= (state_d == ST_CH_LO) ? chan_edit_q[ch_q].lo : chan_edit_q[ch_q].hi;
         cursor_q <= 2'h3;
         dir_up_q <= 1'b1;
      end else if (state_q inside {ST_CH_HI, ST_CH_LO}) begin
         if (va_step) val_q <= bcd_step(val_q, cursor_q, dir_up_q);
         if (rva) dir_up_q <= !dir_up_q;
         if (pdsel) cursor_q <= cursor_q - 2'h1;
      end
   end

   // working copy of the settings; only a save moves it to the stored copy
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 1; i <= 7; i++) chan_edit_q[i] <= CHAN_RESET;
         sys_edit_q <= SYS_RESET;
      end else if (st_chg && state_d == ST_BANNER) begin
         chan_edit_q <= chan_store_q;
         sys_edit_q <= sys_store_q;
      end else begin
         if (st_chg && state_d == ST_CH_DP) chan_edit_q[ch_q].dp <= 2'h0;
         unique case (state_q)
            ST_CH_TYPE: begin
               if (pva) begin
                  chan_edit_q[ch_q].in_type <= next_type(chan_edit_q[ch_q].in_type,
                     ctrl_q[CTRL_NOBLE_BIT], ctrl_q[CTRL_MV_BIT]);
               end
            end
            ST_CH_ONOFF: if (pva) chan_edit_q[ch_q].on <= !chan_edit_q[ch_q].on;
            ST_CH_TUNITS: if (pva) chan_edit_q[ch_q].temp_f <= !chan_edit_q[ch_q].temp_f;
            ST_CH_DP: if (pva) chan_edit_q[ch_q].dp <= chan_edit_q[ch_q].dp + 2'h1;
            ST_CH_HI: if (ps) chan_edit_q[ch_q].hi <= val_q;
            ST_CH_LO: if (ps) chan_edit_q[ch_q].lo <= val_q;
            ST_SYS_DISP: begin
               if (pva) begin
                  sys_edit_q.disp_opt <= (sys_edit_q.disp_opt == LAST_DISP_OPT) ? 3'h0
                                         : sys_edit_q.disp_opt + 3'h1;
               end
            end
            ST_SYS_ELT: if (pva) sys_edit_q.show_elapsed <= !sys_edit_q.show_elapsed;
            ST_SYS_LATCH: if (pva) sys_edit_q.latch <= !sys_edit_q.latch;
            ST_SYS_RANGE: if (pva) sys_edit_q.range <= sys_edit_q.range + 2'h1;
            default: ;
         endcase
      end
   end

   // stored copy plus the write-out of every record, sys record last
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 1; i <= 7; i++) chan_store_q[i] <= CHAN_RESET;
         sys_store_q <= SYS_RESET;
         nv_idx_q <= 3'h0;
         nv_run_q <= 1'b0;
         nv_wr <= 1'b0;
         nv_addr <= 3'h0;
         nv_data <= '0;
      end else begin
         nv_wr <= nv_run_q;
         if (st_chg && state_d == ST_SAVE) begin
            chan_store_q <= chan_edit_q;
            sys_store_q <= sys_edit_q;
            nv_idx_q <= 3'h0;
            nv_run_q <= 1'b1;
         end else if (nv_run_q) begin
            nv_addr <= nv_idx_q;
            nv_data <= (nv_idx_q == SYS_NV_ADDR) ? chan_cfg_t'({32'h0, sys_edit_q})
                       : chan_edit_q[3'(nv_idx_q + 3'h1)];
            nv_idx_q <= nv_idx_q + 3'h1;
            if (nv_idx_q == SYS_NV_ADDR) nv_run_q <= 1'b0;
         end
      end
   end

   // blink phase for the flashing choice and digit
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         blink_cnt_q <= 12'h000;
         blink_q <= 1'b0;
      end else if (ms_tick_q) begin
         blink_cnt_q <= (blink_cnt_q >= BLINK_MS) ? 12'h000 : blink_cnt_q + 12'h001;
         if (blink_cnt_q >= BLINK_MS) blink_q <= !blink_q;
      end
   end

   // display image; prompts stand alone for a while before the value appears
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         disp <= '{ST_NORMAL, 1'b0, 16'h0000, 2'h0, 2'h3, 1'b0};
         setup_lamp <= 1'b0;
      end else begin
         disp.state <= state_q;
         setup_lamp <= in_setup;
         disp.prompt <= (tmr_q < PROMPT_MS) && (state_q inside {ST_CH_TYPE, ST_CH_HI,
                        ST_CH_LO, ST_CH_OFS, ST_CH_TARE, ST_CH_SP, ST_CH_LIM,
                        ST_CH_DB, ST_CH_UNITS});
         disp.cursor <= cursor_q;
         disp.blink <= blink_q && (state_q inside {ST_MENU, ST_CH_HI, ST_CH_LO});
         disp.dp <= (state_q == ST_CH_DP) ? chan_edit_q[ch_q].dp : 2'h0;
         unique case (state_q)
            ST_CODE: disp.value <= {2'h0, code_cnt_q, code_q};
            ST_MENU: disp.value <= {15'h0000, sel_sys_q};
            ST_CH_SEL: disp.value <= {13'h0000, ch_q};
            ST_CH_TYPE: disp.value <= {13'h0000, chan_edit_q[ch_q].in_type};
            ST_CH_ONOFF: disp.value <= {15'h0000, chan_edit_q[ch_q].on};
            ST_CH_TUNITS: disp.value <= {15'h0000, chan_edit_q[ch_q].temp_f};
            ST_CH_DP: disp.value <= 16'h9999;
            ST_CH_HI, ST_CH_LO: disp.value <= val_q;
            ST_SYS_DISP: disp.value <= {13'h0000, sys_edit_q.disp_opt};
            ST_SYS_ELT: disp.value <= {15'h0000, sys_edit_q.show_elapsed};
            ST_SYS_LATCH: disp.value <= {15'h0000, sys_edit_q.latch};
            ST_SYS_RANGE: disp.value <= {14'h0000, sys_edit_q.range};
            default: disp.value <= 16'h0000;
         endcase
      end
   end

   // measurement path uses only stored settings
   assign sel_cfg = (sample_ch == 3'h0) ? CHAN_OFF : chan_store_q[sample_ch];

   scale_map u_scale (
      .mclk(mclk),
      .rst_n(rst_n),
      .sample_valid(sample_valid),
      .sample_ch(sample_ch),
      .sample_raw(sample_raw),
      .cfg(sel_cfg),
      .rd(reading)
   );

   // register port: control write, status and reading read back a cycle later
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= 2'h0;
         last_read_q <= 18'h00000;
         reg_rdata <= 32'h00000000;
      end else begin
         if (reading.valid) last_read_q <= reading.value;
         if (reg_wr && reg_addr == REG_CTRL) ctrl_q <= reg_wdata[1:0];
         if (reg_rd) begin
            unique case (reg_addr)
               REG_CTRL: reg_rdata <= {30'h00000000, ctrl_q};
               REG_STATUS: reg_rdata <= {20'h00000, ch_q, attempts_q, in_setup, 1'b0, state_q};
               REG_READING: reg_rdata <= 32'(last_read_q);
               default: reg_rdata <= 32'h00000000;
            endcase
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end
   end
endmodule

// >>> sim/setup_menu_assertions.sv
module setup_menu_assertions #(
   parameter int CYC_PER_MS = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire setup_menu_pkg::disp_t disp,
   input wire logic setup_lamp,
   input wire logic nv_wr,
   input wire logic [2:0] nv_addr,
   input wire setup_menu_pkg::reading_t reading
);
   import setup_menu_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // lamp must already be lit by the time the passcode prompt shows
   a_lamp_in_setup: assert property (disp.state inside {ST_CODE, ST_MENU} |-> setup_lamp)
      else $error("setup lamp dark in setup");
   a_lamp_idle_off: assert property ((disp.state == ST_NORMAL) [*3] |-> !setup_lamp)
      else $error("setup lamp lit in normal display");
   a_elapsed_exit: assert property ($past(disp.state) == ST_ELAPSED && disp.state != ST_ELAPSED
      |-> disp.state inside {ST_BANNER, ST_NORMAL})
      else $error("bad exit from elapsed display");
   a_code_exit: assert property ($past(disp.state) == ST_CODE && disp.state != ST_CODE
      |-> disp.state inside {ST_MENU, ST_CODE_ERR, ST_SAVE})
      else $error("bad exit from passcode entry");
   a_err_exit: assert property ($past(disp.state) == ST_CODE_ERR && disp.state != ST_CODE_ERR
      |-> disp.state inside {ST_CODE, ST_NORMAL, ST_SAVE})
      else $error("bad exit from code error");
   // nonvolatile records are written only while saving
   a_nv_in_save: assert property (nv_wr |-> disp.state == ST_SAVE)
      else $error("nonvolatile write outside save");
   a_nv_first: assert property ($rose(nv_wr) |-> nv_addr == 3'h0)
      else $error("save does not start at record zero");
   a_nv_step: assert property (nv_wr && nv_addr != 3'h7 |=> nv_wr && nv_addr == $past(nv_addr) + 3'h1)
      else $error("save records not consecutive");
   a_nv_last: assert property (nv_wr && nv_addr == 3'h7 |=> !nv_wr)
      else $error("save runs past last record");
   a_reading_src: assert property (reading.valid |-> $past(sample_valid, 1) || $past(sample_valid, 2))
      else $error("reading without a sample");
endmodule

bind setup_menu_ctrl setup_menu_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.mclk(mclk),
   .rst_n(rst_n), .sample_valid(sample_valid), .disp(disp), .setup_lamp(setup_lamp),
   .nv_wr(nv_wr), .nv_addr(nv_addr), .reading(reading));

// >>> sim/keypad_model.sv
module keypad_model (
   input wire logic mclk,
   output logic [4:0] keys
);
   timeunit 1ns;
   timeprecision 1ns;
   initial keys = 5'h00;
   // one key at a time; the release gap re-arms the press detector
   task automatic press(input int k, input int hold);
      @(posedge mclk);
      keys[k] <= 1'b1;
      repeat (hold) @(posedge mclk);
      keys[k] <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
endmodule

// >>> sim/tb_front_panel_setup_menu.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_front_panel_setup_menu;
   timeunit 1ns;
   timeprecision 1ns;
   import setup_menu_pkg::*;
   logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sample_valid = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [2:0] sample_ch = 3'h0, nv_addr;
   logic [11:0] sample_raw = 12'h000;
   logic [4:0] keys;
   logic setup_lamp, nv_wr;
   disp_t disp;
   chan_cfg_t nv_data;
   reading_t reading;
   int err_total = 0, n_compared = 0, cyc = 0, nv_cnt = 0;
   logic [16:0] lf = 17'h11bef;
   logic [17:0] exp_rd = 18'h0;
   // channel one as the menu walk leaves it: current input, on, no point, 1000 over 0
   chan_cfg_t exp_ch1 = '{IN_CURRENT, 1'b1, 1'b0, 2'h0, 16'h1000, 16'h0000};
   state_t seq[13] = '{ST_CH_LO, ST_CH_OFS, ST_CH_TARE, ST_CH_SP, ST_CH_LIM, ST_CH_DB,
      ST_CH_RLY, ST_CH_UNITS, ST_MENU, ST_SYS_DISP, ST_SYS_ELT, ST_SYS_LATCH, ST_SYS_RANGE};
   keypad_model kp (.mclk(mclk), .keys(keys));
   setup_menu_ctrl #(.CYC_PER_MS(4)) DUT (.mclk(mclk), .rst_n(rst_n), .keys(keys),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_ch(sample_ch),
      .sample_raw(sample_raw), .disp(disp), .setup_lamp(setup_lamp), .nv_wr(nv_wr),
      .nv_addr(nv_addr), .nv_data(nv_data), .reading(reading));
   initial forever #25 mclk = ~mclk;
   function automatic logic [16:0] nxt(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   // full scale 1000 over zero, the reset scaling of every channel
   function automatic logic [17:0] scl(input logic [11:0] r);
      return 18'((1000 * r) >> 12);
   endfunction
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   // bounded wait for a state, then for its prompt text to clear
   task automatic wait_st(input state_t s);
      int i;
      for (i = 0; i < 20000 && disp.state !== s; i++) @(posedge mclk);
      `CHK(disp.state, s)
      for (i = 0; i < 5000 && disp.prompt !== 1'b0; i++) @(posedge mclk);
   endtask
   task automatic enter();
      kp.press(KEY_SETUP, 2);
      wait_st(ST_ELAPSED);
      kp.press(KEY_SETUP, 2);
      wait_st(ST_BANNER);
      `CHK(setup_lamp, 1'b1)
      wait_st(ST_CODE);
   endtask
   task automatic code(input int a, input int b, input int c, input int d);
      kp.press(a, 2);
      kp.press(b, 2);
      kp.press(c, 2);
      kp.press(d, 2);
   endtask
   // cycle ceiling and save-record tally
   always @(posedge mclk) begin
      cyc++;
      if (nv_wr === 1'b1) nv_cnt++;
      if (nv_wr === 1'b1 && nv_addr === 3'h0) `CHK(nv_data, exp_ch1)
      // the whole run needs about 66k cycles, most of it prompt and error timing
      if (cyc == 90000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      lf = nxt(lf);
      wr(REG_CTRL, {30'h0, lf[1:0]});
      rd(REG_CTRL, {30'h0, lf[1:0]});
      rd(8'hfc, 32'h0);
      wr(REG_CTRL, 32'h0);
      $display("register test done");
      enter();
      for (int n = 0; n < 3; n++) begin
         lf = nxt(lf);
         code(KEY_SETUP, lf[3:0] % 5, lf[7:4] % 5, lf[11:8] % 5);
         wait_st(ST_CODE_ERR);
         wait_st(n == 2 ? ST_NORMAL : ST_CODE);
      end
      `CHK(setup_lamp, 1'b0)
      $display("lockout test done");
      enter();
      code(KEY_DSEL, KEY_RESET, KEY_TIME, KEY_VADJ);
      wait_st(ST_MENU);
      `CHK(disp.value, 16'h0000)
      kp.press(KEY_VADJ, 2);
      `CHK(disp.value, 16'h0001)
      kp.press(KEY_VADJ, 2);
      kp.press(KEY_SETUP, 2);
      wait_st(ST_CH_SEL);
      kp.press(KEY_SETUP, 2);
      wait_st(ST_CH_TYPE);
      kp.press(KEY_VADJ, 2);
      `CHK(disp.value[2:0], IN_K)
      repeat (3) kp.press(KEY_VADJ, 2);
      `CHK(disp.value[2:0], IN_CURRENT)
      kp.press(KEY_SETUP, 2);
      wait_st(ST_CH_ONOFF);
      kp.press(KEY_SETUP, 2);
      wait_st(ST_CH_DP);
      `CHK(disp.dp, 2'h0)
      repeat (3) kp.press(KEY_VADJ, 2);
      `CHK(disp.dp, 2'h3)
      kp.press(KEY_VADJ, 2);
      `CHK(disp.dp, 2'h0)
      kp.press(KEY_SETUP, 2);
      wait_st(ST_CH_HI);
      `CHK(disp.cursor, 2'h3)
      kp.press(KEY_DSEL, 2);
      `CHK(disp.cursor, 2'h2)
      kp.press(KEY_VADJ, 2);
      `CHK(disp.value, 16'h1100)
      kp.press(KEY_VADJ, 2);
      `CHK(disp.value, 16'h1000)
      foreach (seq[i]) begin
         if (i == 9) kp.press(KEY_VADJ, 2);
         kp.press(KEY_SETUP, 2);
         wait_st(seq[i]);
      end
      $display("menu walk test done");
      kp.press(KEY_RESET, 9000);
      wait_st(ST_NORMAL);
      `CHK(nv_cnt, 8)
      $display("save test done");
      for (int i = 0; i < 6; i++) begin
         lf = nxt(lf);
         @(posedge mclk);
         sample_valid <= 1'b1;
         // the last sample names no channel, so it must give no reading at all
         sample_ch <= (i == 5) ? 3'h0 : 3'(1 + lf % 7);
         sample_raw <= (i == 0) ? 12'h000 : (i == 1) ? 12'hffe : lf[11:0];
         @(posedge mclk);
         sample_valid <= 1'b0;
         // the reading stands for one cycle only, so look mid-cycle
         @(negedge mclk);
         `CHK(reading.valid, i != 5)
         if (i != 5) begin
            exp_rd = scl(sample_raw);
            `CHK(reading.ch, sample_ch)
            `CHK(reading.value, exp_rd)
         end
      end
      rd(REG_READING, {14'h0, exp_rd});
      rd(REG_STATUS, 32'h00000200);
      $display("scaling test done");
      wrap_up();
   end
endmodule
